// ---- phase_limit_freq_status_regs.vh ----
// register offsets, field layouts and reset values of the limit/frequency/phase register slice
`ifndef PHASE_LIMIT_FREQ_STATUS_REGS_VH
`define PHASE_LIMIT_FREQ_STATUS_REGS_VH

`define OFS_PER_PHASE_LIMIT_FLAGS     8'h2d
`define OFS_PER_PHASE_LIMIT_THRESHOLD 8'h2e
`define OFS_SWITCHING_RATE_STATUS     8'h2f
`define OFS_SWITCHING_RATE_CONFIG     8'h30
`define OFS_STEP_DOWN_SHED_ENABLE     8'h31
`define OFS_POWER_SAVING_PIN_STATE    8'h32
`define OFS_PHASE_ENABLE_STATUS       8'h33

`define CODE_W                        5
`define CODE_MSB                      4
`define PSI_MSB                       1
`define PHASES_MSB                    3
`define SEL_RATE_BIT                  5
`define SEL_LIMIT_BIT                 2
`define SHED_EN_BIT                   0

`define RST_LIMIT_THRESHOLD           5'h00
`define RST_RATE_STATUS               5'h00
`define RST_RATE_CONFIG               5'h00
`define RST_SHED_EN                   1'h1
`define RST_PSI_STATE                 2'h0
`define RST_BYTE                      8'h00

`define KHZ_W                         11
`define COL_P1_LSB                    0
`define COL_P2_LSB                    11
`define COL_P3_LSB                    22
`define COL_P4_LSB                    33

`endif

// ---- phase_limit_freq_status_regs.v ----
// register slice for per-phase limit, switching rate, step-down shedding and phase status
`timescale 1ns/10ps
`include "phase_limit_freq_status_regs.vh"
// Summary of operation
// (RULE_01) limit flag bit n follows phase n+1
// (RULE_02) threshold code is five bits, upper reserved
// (RULE_03) programmed threshold used only when selected
// (RULE_04) resistor threshold tracked continuously by default
// (RULE_05) rate code captured from pin at power-on
// (RULE_06) programmed rate used when both selects set
// (RULE_07) rate code five bits maps to frequency
// (RULE_08) status reports even codes, config takes all
// (RULE_09) bit 0 enables step-down shedding, resets one
// (RULE_10) power-saving pin level in bits 1:0
// (RULE_11) phase enable status in bits 3:0
// (RULE_12) host writes same byte to both selects
// (RULE_13) frequency column follows active phase count
module phase_limit_freq_status_regs #(
    parameter PHASE_FLAGS = 8,
    parameter PHASES      = 4
) (
    // clock, reset, enable
    input  wire                  clk,
    input  wire                  rst,
    input  wire                  ce,
    // register port from the serial interface engine
    input  wire [7:0]            reg_addr,
    input  wire                  reg_wr,
    input  wire [7:0]            reg_wdata,
    input  wire                  reg_rd,
    output reg  [7:0]            reg_rdata,
    // selection registers held elsewhere
    input  wire [7:0]            select_a,
    input  wire [7:0]            select_b,
    // sensed analog state
    input  wire [PHASE_FLAGS-1:0] phase_in_limit,
    input  wire [`CODE_MSB:0]    limit_resistor_code,
    input  wire [`CODE_MSB:0]    rate_set_code,
    input  wire [`PSI_MSB:0]     power_saving_input_level,
    input  wire [PHASES-1:0]     phase_enabled,
    // settings to the modulator
    output reg  [`CODE_MSB:0]    active_limit_code,
    output reg  [`CODE_MSB:0]    active_rate_code,
    output reg  [`KHZ_W-1:0]     switch_freq_khz,
    output reg                   step_down_shed_en
);

    wire [PHASE_FLAGS-1:0] limit_flags;
    reg [`CODE_MSB:0]     limit_threshold;
    reg [`CODE_MSB:0]     rate_status;
    reg                   rate_captured;
    reg [`CODE_MSB:0]     rate_config;
    reg [`PSI_MSB:0]      psi_state;
    reg [PHASES-1:0]      phase_state;
    reg [2:0]             active_count;
    reg [`KHZ_W-1:0]      next_freq;
    reg [7:0]             next_rdata;
    reg [4*`KHZ_W-1:0]    rate_cols;
    integer               i;
    genvar                g;

    // a select pair that disagrees leaves the resistor-derived setting in charge
    wire use_limit_reg = select_a[`SEL_LIMIT_BIT] & select_b[`SEL_LIMIT_BIT];
    wire use_rate_reg  = select_a[`SEL_RATE_BIT] & select_b[`SEL_RATE_BIT];

    // packed frequency row {4 phase, 3 phase, 2 phase, 1 phase} in kHz
    function [4*`KHZ_W-1:0] rate_row;
        input [`CODE_MSB:0] code;
        begin
            case (code)
                5'h00: rate_row = {11'd221,  11'd293,  11'd223,  11'd232};
                5'h01: rate_row = {11'd244,  11'd329,  11'd243,  11'd252};
                5'h02: rate_row = {11'd266,  11'd358,  11'd264,  11'd272};
                5'h03: rate_row = {11'd293,  11'd381,  11'd294,  11'd297};
                5'h04: rate_row = {11'd307,  11'd407,  11'd317,  11'd322};
                5'h05: rate_row = {11'd333,  11'd450,  11'd335,  11'd340};
                5'h06: rate_row = {11'd351,  11'd480,  11'd352,  11'd361};
                5'h07: rate_row = {11'd373,  11'd510,  11'd380,  11'd385};
                5'h08: rate_row = {11'd394,  11'd530,  11'd399,  11'd413};
                5'h09: rate_row = {11'd421,  11'd562,  11'd420,  11'd435};
                5'h0a: rate_row = {11'd449,  11'd600,  11'd436,  11'd456};
                5'h0b: rate_row = {11'd469,  11'd614,  11'd454,  11'd478};
                5'h0c: rate_row = {11'd479,  11'd631,  11'd483,  11'd500};
                5'h0d: rate_row = {11'd509,  11'd663,  11'd508,  11'd509};
                5'h0e: rate_row = {11'd518,  11'd688,  11'd526,  11'd518};
                5'h0f: rate_row = {11'd543,  11'd722,  11'd543,  11'd540};
                5'h10: rate_row = {11'd581,  11'd789,  11'd583,  11'd578};
                5'h11: rate_row = {11'd649,  11'd859,  11'd656,  11'd638};
                5'h12: rate_row = {11'd708,  11'd930,  11'd698,  11'd698};
                5'h13: rate_row = {11'd751,  11'd1010, 11'd771,  11'd758};
                5'h14: rate_row = {11'd799,  11'd1095, 11'd807,  11'd818};
                5'h15: rate_row = {11'd866,  11'd1147, 11'd860,  11'd878};
                5'h16: rate_row = {11'd919,  11'd1233, 11'd899,  11'd938};
                5'h17: rate_row = {11'd964,  11'd1260, 11'd950,  11'd972};
                5'h18: rate_row = {11'd993,  11'd1341, 11'd1003, 11'd1014};
                5'h19: rate_row = {11'd1059, 11'd1372, 11'd1052, 11'd1067};
                5'h1a: rate_row = {11'd1098, 11'd1450, 11'd1096, 11'd1106};
                5'h1b: rate_row = {11'd1141, 11'd1539, 11'd1154, 11'd1155};
                5'h1c: rate_row = {11'd1200, 11'd1619, 11'd1205, 11'd1201};
                5'h1d: rate_row = {11'd1236, 11'd1618, 11'd1227, 11'd1245};
                5'h1e: rate_row = {11'd1291, 11'd1674, 11'd1274, 11'd1280};
                default: rate_row = {11'd1312, 11'd1724, 11'd1316, 11'd1330};
            endcase
        end
    endfunction

    // frequency column chosen by the number of phases currently enabled
    // zero enabled phases falls back to the single-phase column
    always @* begin
        active_count = 3'h0;
        rate_cols    = rate_row(active_rate_code);
        for (i = 0; i < PHASES; i = i + 1) begin
            active_count = active_count + {2'h0, phase_state[i]};
        end
        case (active_count)
            3'h4:    next_freq = rate_cols[`COL_P4_LSB +: `KHZ_W]; // RULE_13
            3'h3:    next_freq = rate_cols[`COL_P3_LSB +: `KHZ_W]; // RULE_13
            3'h2:    next_freq = rate_cols[`COL_P2_LSB +: `KHZ_W]; // RULE_13
            default: next_freq = rate_cols[`COL_P1_LSB +: `KHZ_W]; // RULE_13
        endcase
    end

    // read mux; reserved bits and unmapped offsets read zero
    always @* begin
        next_rdata = `RST_BYTE;
        case (reg_addr)
            `OFS_PER_PHASE_LIMIT_FLAGS:     next_rdata = limit_flags; // RULE_01
            `OFS_PER_PHASE_LIMIT_THRESHOLD: next_rdata = {3'h0, limit_threshold}; // RULE_02
            `OFS_SWITCHING_RATE_STATUS:     next_rdata = {3'h0, rate_status}; // RULE_07
            `OFS_SWITCHING_RATE_CONFIG:     next_rdata = {3'h0, rate_config}; // RULE_07
            `OFS_STEP_DOWN_SHED_ENABLE:     next_rdata = {7'h00, step_down_shed_en}; // RULE_09
            `OFS_POWER_SAVING_PIN_STATE:    next_rdata = {6'h00, psi_state}; // RULE_10
            `OFS_PHASE_ENABLE_STATUS:       next_rdata = {4'h0, phase_state}; // RULE_11
            default:                        next_rdata = `RST_BYTE;
        endcase
    end

    // one flop per phase flag, so the flag drops on the next enabled edge after the phase leaves limiting
    generate
        for (g = 0; g < PHASE_FLAGS; g = g + 1) begin : g_limit_flag
            reg flag;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    flag <= 1'b0;
                end else if (ce) begin
                    flag <= phase_in_limit[g]; // RULE_01
                end
            end
            assign limit_flags[g] = flag;
        end
    endgenerate

    // sampled pin and phase state, refreshed on every enabled edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            psi_state     <= `RST_PSI_STATE;
            phase_state   <= {PHASES{1'b0}};
            rate_status   <= `RST_RATE_STATUS;
            rate_captured <= 1'b0;
        end else if (ce) begin
            psi_state   <= power_saving_input_level; // RULE_10
            phase_state <= phase_enabled; // RULE_11
            // pin resistor only resolves even codes, so the odd step is dropped;
            // the pin is not looked at again until the next reset
            if (!rate_captured) begin
                rate_status   <= {rate_set_code[`CODE_MSB:1], 1'b0}; // RULE_05 RULE_08
                rate_captured <= 1'b1; // RULE_05
            end
        end
    end

    // host writes; read-only and unmapped offsets are ignored
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            limit_threshold   <= `RST_LIMIT_THRESHOLD;
            rate_config       <= `RST_RATE_CONFIG;
            step_down_shed_en <= `RST_SHED_EN;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `OFS_PER_PHASE_LIMIT_THRESHOLD:
                    limit_threshold <= reg_wdata[`CODE_MSB:0]; // RULE_02
                `OFS_SWITCHING_RATE_CONFIG:
                    rate_config <= reg_wdata[`CODE_MSB:0]; // RULE_08
                `OFS_STEP_DOWN_SHED_ENABLE:
                    step_down_shed_en <= reg_wdata[`SHED_EN_BIT]; // RULE_09
                default: ;
            endcase
        end
    end

    // settings to the modulator lag the registers by one edge, the frequency by two
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            active_limit_code <= `RST_LIMIT_THRESHOLD;
            active_rate_code  <= `RST_RATE_STATUS;
            switch_freq_khz   <= {`KHZ_W{1'b0}};
        end else if (ce) begin
            // selection waits for both select bytes to set the bit
            if (use_limit_reg) begin
                active_limit_code <= limit_threshold; // RULE_03 RULE_12
            end else begin
                active_limit_code <= limit_resistor_code; // RULE_04
            end
            if (use_rate_reg) begin
                active_rate_code <= rate_config; // RULE_06 RULE_12
            end else begin
                active_rate_code <= rate_status; // RULE_06
            end
            switch_freq_khz <= next_freq; // RULE_07
        end
    end

    // read data holds between reads, so the serial engine may shift it out late
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `RST_BYTE;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // phase_limit_freq_status_regs

// ---- regs_chk.sv ----
// assertions on the ports of the limit/rate/phase register slice
`timescale 1ns/10ps
module regs_chk #(
    parameter PHASE_FLAGS = 8,
    parameter PHASES      = 4
) (
    // clock, reset and register port
    input wire                   clk,
    input wire                   rst,
    input wire                   ce,
    input wire [7:0]             reg_addr,
    input wire                   reg_wr,
    input wire [7:0]             reg_wdata,
    input wire                   reg_rd,
    input wire [7:0]             reg_rdata,
    // selects, sensed state and settings
    input wire [7:0]             select_a,
    input wire [7:0]             select_b,
    input wire [PHASE_FLAGS-1:0] phase_in_limit,
    input wire [4:0]             limit_resistor_code,
    input wire [1:0]             power_saving_input_level,
    input wire [PHASES-1:0]      phase_enabled,
    input wire [4:0]             active_limit_code,
    input wire [4:0]             active_rate_code,
    input wire [10:0]            switch_freq_khz,
    input wire                   step_down_shed_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // status lags its inputs by one edge, so the edge after reset is left out
    sequence rds(a);
        ce && reg_rd && reg_addr == a && !$past(rst);
    endsequence
    AST_FLAGS: assert property (rds(8'h2d) |=> reg_rdata == $past(phase_in_limit, 2))
        else $error("limit flag read wrong");
    AST_PSI: assert property (rds(8'h32) |=> reg_rdata == {6'h0, $past(power_saving_input_level, 2)})
        else $error("power saving read wrong");
    AST_PHASE: assert property (rds(8'h33) |=> reg_rdata == {4'h0, $past(phase_enabled, 2)})
        else $error("phase status read wrong");
    AST_EVEN: assert property (rds(8'h2f) |=> reg_rdata[0] == 1'b0 && reg_rdata[7:5] == 3'h0)
        else $error("rate status not even");
    AST_UNMAPPED: assert property (ce && reg_rd && (reg_addr < 8'h2d || reg_addr > 8'h33) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved");
    AST_LIMIT_PIN: assert property (ce && !(select_a[2] && select_b[2]) |=> active_limit_code == $past(limit_resistor_code))
        else $error("resistor threshold not used");
    AST_SHED: assert property (ce && reg_wr && reg_addr == 8'h31 |=> step_down_shed_en == $past(reg_wdata[0]))
        else $error("shed enable not written");
    AST_RATE_SEL: assert property (ce && select_a[5] && select_b[5] && reg_wr && reg_addr == 8'h30 |=> ##1 active_rate_code == $past(reg_wdata[4:0], 2))
        else $error("programmed rate not used");
    AST_FREQ: assert property (ce && active_rate_code == 5'h1f && phase_enabled == 4'hf && $past(phase_enabled) == 4'hf |=> switch_freq_khz == 11'h520)
        else $error("four phase top rate wrong");
    cover property (rds(8'h2d) ##1 reg_rdata != 8'h00);
    cover property (active_limit_code == 5'h1f);
    cover property (switch_freq_khz == 11'h520);
endmodule // regs_chk
bind phase_limit_freq_status_regs regs_chk #(.PHASE_FLAGS(PHASE_FLAGS), .PHASES(PHASES)) u_chk (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .select_a(select_a), .select_b(select_b),
    .phase_in_limit(phase_in_limit), .limit_resistor_code(limit_resistor_code),
    .power_saving_input_level(power_saving_input_level), .phase_enabled(phase_enabled),
    .active_limit_code(active_limit_code), .active_rate_code(active_rate_code),
    .switch_freq_khz(switch_freq_khz), .step_down_shed_en(step_down_shed_en));

// ---- regs_host.sv ----
// register-port host that also owns the paired select bytes
`timescale 1ns/10ps
module regs_host (
    // clock and read data
    input wire       clk,
    input wire [7:0] reg_rdata,
    // requests and select bytes
    output reg [7:0] reg_addr,
    output reg       reg_wr,
    output reg [7:0] reg_wdata,
    output reg       reg_rd,
    output reg [7:0] select_a,
    output reg [7:0] select_b
);
    initial {reg_addr, reg_wr, reg_wdata, reg_rd, select_a, select_b} = 34'h0;
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clk);
            reg_wr = 1'b0;
            // released data must not look like the last byte
            reg_wdata = ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clk);
            reg_rd = 1'b0;
            d = reg_rdata;
        end
    endtask
    // same byte to both selects, one after the other
    task sel(input [7:0] b);
        begin
            @(negedge clk);
            select_a = b;
            @(negedge clk);
            select_b = b;
        end
    endtask
endmodule // regs_host

// ---- phase_limit_freq_status_regs_test.sv ----
// self-checking bench for the limit/rate/phase register slice
`timescale 1ns/10ps
module phase_limit_freq_status_regs_test;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         ce = 1'b1;
    reg  [7:0]  lim = 8'h00;
    reg  [4:0]  res_code = 5'h0a;
    reg  [4:0]  rate_pin = 5'h07;
    reg  [1:0]  power_saving_input = 2'h0;
    reg  [3:0]  ph_en = 4'hf;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata, select_a, select_b;
    wire        reg_wr, reg_rd, shed;
    wire [4:0]  alc, arc;
    wire [10:0] khz;
    reg  [7:0]  d;
    integer     fails = 0;
    integer     checked = 0;
    initial forever #20 clk = ~clk;
    phase_limit_freq_status_regs u_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .select_a(select_a), .select_b(select_b), .phase_in_limit(lim),
        .limit_resistor_code(res_code), .rate_set_code(rate_pin),
        .power_saving_input_level(power_saving_input), .phase_enabled(ph_en), .active_limit_code(alc),
        .active_rate_code(arc), .switch_freq_khz(khz), .step_down_shed_en(shed));
    regs_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .select_a(select_a), .select_b(select_b));
    task test_done;
        begin
            if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [10:0] got, input [10:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("MISMATCH %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        begin
            u_host.rd(a, d);
            chk({3'h0, d}, {3'h0, e});
        end
    endtask
    task t_defaults;
        begin
            rdc(8'h2e, 8'h00);
            rdc(8'h31, 8'h01);
            rdc(8'h2f, 8'h06);
            rdc(8'h40, 8'h00);
        end
    endtask
    task t_status;
        begin
            lim = 8'h81;
            power_saving_input = 2'h2;
            ph_en = 4'h5;
            u_host.wr(8'h2d, 8'h00);
            rdc(8'h2d, 8'h81);
            rdc(8'h32, 8'h02);
            rdc(8'h33, 8'h05);
            ph_en = 4'hf;
        end
    endtask
    task t_limit;
        begin
            u_host.wr(8'h2e, 8'hff);
            rdc(8'h2e, 8'h1f);
            res_code = 5'h0c;
            repeat (2) @(negedge clk);
            chk({6'h0, alc}, 11'h00c);
            u_host.sel(8'h04);
            repeat (2) @(negedge clk);
            chk({6'h0, alc}, 11'h01f);
            u_host.sel(8'h00);
        end
    endtask
    task t_rate;
        begin
            chk({6'h0, arc}, 11'h006);
            u_host.wr(8'h30, 8'hff);
            @(negedge clk);
            chk({6'h0, arc}, 11'h006);
            u_host.sel(8'h20);
            u_host.wr(8'h30, 8'hff);
            rdc(8'h30, 8'h1f);
            chk({6'h0, arc}, 11'h01f);
            @(negedge clk);
            chk(khz, 11'h520);
            ph_en = 4'h1;
            repeat (3) @(negedge clk);
            chk(khz, 11'h532);
        end
    endtask
    task t_shed;
        begin
            ce = 1'b0;
            u_host.wr(8'h31, 8'h00);
            ce = 1'b1;
            chk({10'h0, shed}, 11'h001);
            u_host.wr(8'h31, 8'h00);
            chk({10'h0, shed}, 11'h000);
        end
    endtask
    task t_reset;
        begin
            rate_pin = 5'h1d;
            rdc(8'h2f, 8'h06);
            rst = 1'b1;
            repeat (2) @(negedge clk);
            rst = 1'b0;
            @(negedge clk);
            rdc(8'h2f, 8'h1c);
            rdc(8'h31, 8'h01);
        end
    endtask
    initial begin
        #100000;
        fails = fails + 1;
        test_done;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_defaults;
        t_status;
        t_limit;
        t_rate;
        t_shed;
        t_reset;
        test_done;
    end
endmodule // phase_limit_freq_status_regs_test
